/* core/jbs_tap_fsm.sv */
`timescale 1ns/1ps
module jbs_tap_fsm
    import jbs_pkg::*;
(
    input wire logic tck_in,
    input wire logic rst_in,
    input wire logic tms_in,
    jbs_tap_if.fsm tap
);
    jbs_tap_state_t state_r;
    jbs_tap_state_t state_nxt;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_TLR: state_nxt = tms_in ? ST_TLR : ST_RTI;
            ST_RTI: state_nxt = tms_in ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: state_nxt = tms_in ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: state_nxt = tms_in ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: state_nxt = tms_in ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: state_nxt = tms_in ? ST_UPD_DR : ST_PA_DR;
            ST_PA_DR: state_nxt = tms_in ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: state_nxt = tms_in ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: state_nxt = tms_in ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: state_nxt = tms_in ? ST_TLR : ST_CAP_IR;
            ST_CAP_IR: state_nxt = tms_in ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: state_nxt = tms_in ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: state_nxt = tms_in ? ST_UPD_IR : ST_PA_IR;
            ST_PA_IR: state_nxt = tms_in ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: state_nxt = tms_in ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: state_nxt = tms_in ? ST_SEL_DR : ST_RTI;
            default: state_nxt = ST_TLR;
        endcase
    end

    // Sixteen-state sequencer on rising test clock
    always_ff @(posedge tck_in) begin
        if (rst_in) begin
            state_r <= ST_TLR;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign tap.state = state_r;
    assign tap.tlr = (state_r == ST_TLR);
    assign tap.capture_dr = (state_r == ST_CAP_DR);
    assign tap.shift_dr = (state_r == ST_SH_DR);
    assign tap.update_dr = (state_r == ST_UPD_DR);
    assign tap.capture_ir = (state_r == ST_CAP_IR);
    assign tap.shift_ir = (state_r == ST_SH_IR);
    assign tap.update_ir = (state_r == ST_UPD_IR);
endmodule

/* core/jbs_tap_top.sv */
`timescale 1ns/1ps
// How it works
// - Instruction register is ten bits; each IR scan shifts ten bits.
// - BYPASS puts one flip-flop between data in and data out.
// - IDCODE puts the 32-bit identification word on the serial path.
// - ID word: version, part number, manufacturer, one constant bit, MSB first.
// - Identification word bit zero is always one.
// - SAMPLE/PRELOAD snapshots pins, loads a pattern for later driving.
// - EXTEST drives the scan pattern on outputs, captures inputs.
// - Without scan cells, EXTEST and SAMPLE/PRELOAD select the bypass bit.
// - Scan register length is a per-variant constant, 288 to 480 cells.
// - When the test port is disabled, its four pins are released.
// - Programming instructions erase, address, write and verify nonvolatile storage.
module jbs_tap_top
    import jbs_pkg::*;
#(
    parameter int BSR_LEN = BSR_LEN_DEF,
    parameter bit HAS_BSR = 1'b1,
    parameter int PROG_DR_LEN = PROG_DR_LEN_DEF,
    // Arbitrary identification fields
    parameter logic [3:0] ID_VERSION = 4'h1,
    parameter logic [15:0] ID_PART = 16'hA5C3,
    parameter logic [10:0] ID_MFR = 11'h2B5,
    localparam int N_IO = BSR_LEN / CELLS_PER_PIN
) (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic tck_in,
    input wire logic tms_in,
    input wire logic tdi_in,
    input wire logic jtag_en_in,
    output logic tdo_out,
    output logic tdo_oe_out,
    output logic jtag_released_out,
    input wire logic [N_IO-1:0] pad_in,
    input wire logic [N_IO-1:0] core_out_in,
    input wire logic [N_IO-1:0] core_oe_in,
    output logic [N_IO-1:0] pad_out,
    output logic [N_IO-1:0] pad_oe_out,
    output logic extest_active_out,
    output logic prog_mode_out,
    input wire logic [PROG_DR_LEN-1:0] prog_rd_data_in,
    output logic prog_cmd_valid_out,
    output jbs_prog_op_t prog_cmd_op_out,
    output logic [PROG_DR_LEN-1:0] prog_cmd_data_out
);

    // Instruction decode shared by capture, shift and output select
    function automatic jbs_dr_sel_t dr_select(input logic [IR_LEN-1:0] ir);
        jbs_dr_sel_t sel;
        sel = SEL_BYPASS;
        if (ir == IR_EXTEST || ir == IR_SAMPLE) begin
            sel = HAS_BSR ? SEL_BSR : SEL_BYPASS;
        end else if (ir == IR_IDCODE) begin
            sel = SEL_IDCODE;
        end else if (ir == IR_PROG_ADDR || ir == IR_PROG_WRITE || ir == IR_PROG_VERIFY) begin
            sel = SEL_PROG;
        end
        return sel;
    endfunction

    function automatic jbs_prog_op_t prog_op(input logic [IR_LEN-1:0] ir);
        jbs_prog_op_t op;
        op = OP_ADDR;
        if (ir == IR_PROG_WRITE) begin
            op = OP_WRITE;
        end else if (ir == IR_PROG_VERIFY) begin
            op = OP_VERIFY;
        end else if (ir == IR_PROG_ERASE) begin
            op = OP_ERASE;
        end
        return op;
    endfunction

    localparam logic [ID_LEN-1:0] ID_WORD = (ID_LEN'(ID_VERSION) << ID_VER_LSB)
        | (ID_LEN'(ID_PART) << ID_PART_LSB) | (ID_LEN'(ID_MFR) << ID_MFR_LSB)
        | (ID_LEN'(ID_ONE_VAL) << ID_ONE_BIT);

    // ---------------- Test clock domain ----------------
    jbs_tap_if tap ();

    logic rst_meta_r;
    logic rst_sync_r;
    logic en_meta_r;
    logic en_sync_r;
    logic tap_rst;
    logic [N_IO-1:0] pad_meta_r;
    logic [N_IO-1:0] pad_sync_r;
    logic [N_IO-1:0] cout_meta_r;
    logic [N_IO-1:0] cout_sync_r;
    logic [N_IO-1:0] coe_meta_r;
    logic [N_IO-1:0] coe_sync_r;
    logic [PROG_DR_LEN-1:0] rd_meta_r;
    logic [PROG_DR_LEN-1:0] rd_sync_r;
    logic [IR_LEN-1:0] ir_sh_r;
    logic [IR_LEN-1:0] ir_r;
    jbs_dr_sel_t sel;
    logic bypass_r;
    logic [ID_LEN-1:0] id_sh_r;
    logic [BSR_LEN-1:0] bsr_sh_r;
    logic [BSR_LEN-1:0] bsr_cap;
    logic [BSR_LEN-1:0] bsr_upd_r;
    logic upd_tgl_r;
    logic [PROG_DR_LEN-1:0] prog_sh_r;
    logic [PROG_DR_LEN-1:0] prog_hold_r;
    jbs_prog_op_t prog_op_r;
    logic prog_tgl_r;
    logic prog_mode_t_r;
    logic extest_t_r;
    logic tdo_r;
    logic tdo_oe_r;
    logic serial_bit;

    // Reset and enable crossing into the test clock
    always_ff @(posedge tck_in) begin
        rst_meta_r <= srst_in;
        rst_sync_r <= rst_meta_r;
        en_meta_r <= jtag_en_in;
        en_sync_r <= en_meta_r;
    end

    assign tap_rst = rst_sync_r | ~en_sync_r;

    jbs_tap_fsm u_fsm (
        .tck_in(tck_in),
        .rst_in(tap_rst),
        .tms_in(tms_in),
        .tap(tap.fsm)
    );

    // Pin and core values crossing into the test clock
    always_ff @(posedge tck_in) begin
        pad_meta_r <= pad_in;
        pad_sync_r <= pad_meta_r;
        cout_meta_r <= core_out_in;
        cout_sync_r <= cout_meta_r;
        coe_meta_r <= core_oe_in;
        coe_sync_r <= coe_meta_r;
        rd_meta_r <= prog_rd_data_in;
        rd_sync_r <= rd_meta_r;
    end

    // Three cells per pin: input, output data, output enable
    for (genvar g = 0; g < N_IO; g++) begin : g_cell
        assign bsr_cap[g*CELLS_PER_PIN+CELL_IN] = pad_sync_r[g];
        assign bsr_cap[g*CELLS_PER_PIN+CELL_OUT] = cout_sync_r[g];
        assign bsr_cap[g*CELLS_PER_PIN+CELL_OE] = coe_sync_r[g];
    end

    assign sel = dr_select(ir_r);

    // Instruction register
    always_ff @(posedge tck_in) begin
        if (tap_rst || tap.tlr) begin
            ir_sh_r <= IR_CAPTURE_VAL;
            ir_r <= IR_IDCODE;
        end else begin
            if (tap.capture_ir) begin
                ir_sh_r <= IR_CAPTURE_VAL;
            end else if (tap.shift_ir) begin
                ir_sh_r <= {tdi_in, ir_sh_r[IR_LEN-1:1]};
            end
            if (tap.update_ir) begin
                ir_r <= ir_sh_r;
            end
        end
    end

    // Bypass bit
    always_ff @(posedge tck_in) begin
        if (tap_rst) begin
            bypass_r <= 1'b0;
        end else if (tap.capture_dr && sel == SEL_BYPASS) begin
            bypass_r <= 1'b0;
        end else if (tap.shift_dr && sel == SEL_BYPASS) begin
            bypass_r <= tdi_in;
        end
    end

    // Identification shifter
    always_ff @(posedge tck_in) begin
        if (tap_rst) begin
            id_sh_r <= ID_WORD;
        end else if (tap.capture_dr && sel == SEL_IDCODE) begin
            id_sh_r <= ID_WORD;
        end else if (tap.shift_dr && sel == SEL_IDCODE) begin
            id_sh_r <= {tdi_in, id_sh_r[ID_LEN-1:1]};
        end
    end

    // Boundary-scan shifter and update stage
    always_ff @(posedge tck_in) begin
        if (tap_rst) begin
            bsr_sh_r <= '0;
            bsr_upd_r <= '0;
            upd_tgl_r <= 1'b0;
        end else if (sel == SEL_BSR) begin
            if (tap.capture_dr) begin
                bsr_sh_r <= bsr_cap;
            end else if (tap.shift_dr) begin
                bsr_sh_r <= {tdi_in, bsr_sh_r[BSR_LEN-1:1]};
            end
            if (tap.update_dr) begin
                bsr_upd_r <= bsr_sh_r;
                upd_tgl_r <= ~upd_tgl_r;
            end
        end
    end

    // Programming shifter, commands and mode
    always_ff @(posedge tck_in) begin
        if (tap_rst) begin
            prog_sh_r <= '0;
            prog_hold_r <= '0;
            prog_op_r <= OP_ADDR;
            prog_tgl_r <= 1'b0;
            prog_mode_t_r <= 1'b0;
        end else begin
            if (tap.capture_dr && sel == SEL_PROG) begin
                prog_sh_r <= rd_sync_r;
            end else if (tap.shift_dr && sel == SEL_PROG) begin
                prog_sh_r <= {tdi_in, prog_sh_r[PROG_DR_LEN-1:1]};
            end
            if (tap.update_dr && sel == SEL_PROG && prog_mode_t_r) begin
                prog_hold_r <= prog_sh_r;
                prog_op_r <= prog_op(ir_r);
                prog_tgl_r <= ~prog_tgl_r;
            end else if (tap.update_ir && ir_sh_r == IR_PROG_ERASE && prog_mode_t_r) begin
                prog_op_r <= OP_ERASE;
                prog_tgl_r <= ~prog_tgl_r;
            end
            if (tap.update_ir && ir_sh_r == IR_PROG_ENTER) begin
                prog_mode_t_r <= 1'b1;
            end else if (tap.update_ir && ir_sh_r == IR_PROG_EXIT) begin
                prog_mode_t_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge tck_in) begin
        if (tap_rst || tap.tlr) begin
            extest_t_r <= 1'b0;
        end else if (tap.update_ir) begin
            extest_t_r <= HAS_BSR && ir_sh_r == IR_EXTEST;
        end
    end

    always_comb begin
        serial_bit = bypass_r;
        if (tap.shift_ir) begin
            serial_bit = ir_sh_r[0];
        end else if (sel == SEL_IDCODE) begin
            serial_bit = id_sh_r[0];
        end else if (sel == SEL_BSR) begin
            serial_bit = bsr_sh_r[0];
        end else if (sel == SEL_PROG) begin
            serial_bit = prog_sh_r[0];
        end
    end

    // Serial output changes on the falling test clock
    always_ff @(negedge tck_in) begin
        if (tap_rst) begin
            tdo_r <= 1'b0;
            tdo_oe_r <= 1'b0;
        end else begin
            tdo_r <= serial_bit;
            tdo_oe_r <= tap.shift_dr | tap.shift_ir;
        end
    end

    assign tdo_out = tdo_r;
    assign tdo_oe_out = tdo_oe_r;

    // ---------------- System clock domain ----------------
    logic ext_meta_r;
    logic ext_sync_r;
    logic pm_meta_r;
    logic pm_sync_r;
    logic jen_meta_r;
    logic jen_sync_r;
    logic [2:0] upd_sync_r;
    logic [2:0] prg_sync_r;
    logic [BSR_LEN-1:0] bsr_cp_r;
    logic released_r;
    logic [N_IO-1:0] pad_out_r;
    logic [N_IO-1:0] pad_oe_r;
    logic cmd_valid_r;
    jbs_prog_op_t cmd_op_r;
    logic [PROG_DR_LEN-1:0] cmd_data_r;

    always_ff @(posedge clock_in) begin
        ext_meta_r <= extest_t_r;
        ext_sync_r <= ext_meta_r;
        pm_meta_r <= prog_mode_t_r;
        pm_sync_r <= pm_meta_r;
        jen_meta_r <= jtag_en_in;
        jen_sync_r <= jen_meta_r;
        upd_sync_r <= {upd_sync_r[1:0], upd_tgl_r};
        prg_sync_r <= {prg_sync_r[1:0], prog_tgl_r};
    end

    // Update pattern taken once its toggle has settled
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            bsr_cp_r <= '0;
        end else if (upd_sync_r[2] != upd_sync_r[1]) begin
            bsr_cp_r <= bsr_upd_r;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            cmd_valid_r <= 1'b0;
            cmd_op_r <= OP_ADDR;
            cmd_data_r <= '0;
        end else begin
            cmd_valid_r <= prg_sync_r[2] != prg_sync_r[1];
            if (prg_sync_r[2] != prg_sync_r[1]) begin
                cmd_op_r <= prog_op_r;
                cmd_data_r <= prog_hold_r;
            end
        end
    end

    // Pin drivers: programming tristates, EXTEST uses the pattern
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            pad_out_r <= '0;
            pad_oe_r <= '0;
            released_r <= 1'b0;
        end else begin
            released_r <= ~jen_sync_r;
            for (int i = 0; i < N_IO; i++) begin
                if (pm_sync_r) begin
                    pad_out_r[i] <= 1'b0;
                    pad_oe_r[i] <= 1'b0;
                end else if (ext_sync_r) begin
                    pad_out_r[i] <= bsr_cp_r[i*CELLS_PER_PIN+CELL_OUT];
                    pad_oe_r[i] <= bsr_cp_r[i*CELLS_PER_PIN+CELL_OE];
                end else begin
                    pad_out_r[i] <= core_out_in[i];
                    pad_oe_r[i] <= core_oe_in[i];
                end
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            extest_active_out <= 1'b0;
            prog_mode_out <= 1'b0;
        end else begin
            extest_active_out <= ext_sync_r;
            prog_mode_out <= pm_sync_r;
        end
    end

    assign jtag_released_out = released_r;
    assign pad_out = pad_out_r;
    assign pad_oe_out = pad_oe_r;
    assign prog_cmd_valid_out = cmd_valid_r;
    assign prog_cmd_op_out = cmd_op_r;
    assign prog_cmd_data_out = cmd_data_r;
endmodule

/* inc/jbs_pkg.sv */
package jbs_pkg;

    // Instruction register
    localparam int IR_LEN = 10;
    localparam logic [9:0] IR_CAPTURE_VAL = 10'h001;
    localparam logic [9:0] IR_EXTEST = 10'h000;
    localparam logic [9:0] IR_SAMPLE = 10'h055;
    localparam logic [9:0] IR_IDCODE = 10'h059;
    localparam logic [9:0] IR_BYPASS = 10'h3FF;
    localparam logic [9:0] IR_PROG_ENTER = 10'h2CC;
    localparam logic [9:0] IR_PROG_EXIT = 10'h079;
    localparam logic [9:0] IR_PROG_ERASE = 10'h2F2;
    localparam logic [9:0] IR_PROG_ADDR = 10'h203;
    localparam logic [9:0] IR_PROG_WRITE = 10'h2F4;
    localparam logic [9:0] IR_PROG_VERIFY = 10'h205;

    // Identification word layout
    localparam int ID_LEN = 32;
    localparam int ID_VER_LSB = 28;
    localparam int ID_PART_LSB = 12;
    localparam int ID_MFR_LSB = 1;
    localparam int ID_ONE_BIT = 0;
    localparam logic ID_ONE_VAL = 1'b1;

    // Boundary-scan register
    localparam int BSR_LEN_DEF = 288;
    localparam int BSR_LEN_MAX = 480;
    localparam int CELLS_PER_PIN = 3;
    localparam int CELL_IN = 0;
    localparam int CELL_OUT = 1;
    localparam int CELL_OE = 2;

    // Programming data register
    localparam int PROG_DR_LEN_DEF = 16;

    typedef enum logic [3:0] {
        ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR,
        ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UPD_IR
    } jbs_tap_state_t;

    typedef enum logic [1:0] {
        SEL_BYPASS, SEL_IDCODE, SEL_BSR, SEL_PROG
    } jbs_dr_sel_t;

    typedef enum logic [1:0] {
        OP_ERASE, OP_ADDR, OP_WRITE, OP_VERIFY
    } jbs_prog_op_t;

endpackage

/* inc/jbs_tap_if.sv */
`timescale 1ns/1ps
interface jbs_tap_if;
    import jbs_pkg::*;
    jbs_tap_state_t state;
    logic tlr;
    logic capture_dr;
    logic shift_dr;
    logic update_dr;
    logic capture_ir;
    logic shift_ir;
    logic update_ir;
    modport fsm (output state, tlr, capture_dr, shift_dr, update_dr, capture_ir, shift_ir,
        update_ir);
    modport core (input state, tlr, capture_dr, shift_dr, update_dr, capture_ir, shift_ir,
        update_ir);
endinterface

/* sim/jbs_tap_checker.sv */
`timescale 1ns/1ps
module jbs_tap_checker
    import jbs_pkg::*;
#(
    parameter int BSR_LEN = BSR_LEN_DEF,
    parameter int PROG_DR_LEN = PROG_DR_LEN_DEF,
    localparam int N_IO = BSR_LEN / CELLS_PER_PIN
) (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic jtag_en_in,
    input wire logic tdo_oe_out,
    input wire logic jtag_released_out,
    input wire logic [N_IO-1:0] core_out_in,
    input wire logic [N_IO-1:0] core_oe_in,
    input wire logic [N_IO-1:0] pad_out,
    input wire logic [N_IO-1:0] pad_oe_out,
    input wire logic extest_active_out,
    input wire logic prog_mode_out,
    input wire logic prog_cmd_valid_out,
    input wire jbs_prog_op_t prog_cmd_op_out,
    input wire logic [PROG_DR_LEN-1:0] prog_cmd_data_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (srst_in);
    sequence s_normal;
        !prog_mode_out && !extest_active_out;
    endsequence
    sequence s_prog;
        prog_mode_out;
    endsequence
    a_pins_released: assert property ($fell(jtag_en_in) |-> ##[2:4] jtag_released_out)
        else $error("test pins not released");
    a_pins_return: assert property ($rose(jtag_en_in) |-> ##[2:4] !jtag_released_out)
        else $error("test pins not returned");
    a_oe_released: assert property (jtag_released_out |-> !tdo_oe_out)
        else $error("serial output driven while released");
    a_cmd_pulse: assert property (prog_cmd_valid_out |=> !prog_cmd_valid_out)
        else $error("command strobe longer than one cycle");
    a_cmd_mode: assert property (prog_cmd_valid_out |-> prog_mode_out)
        else $error("command outside programming mode");
    a_cmd_hold: assert property (!$rose(prog_cmd_valid_out) |->
        $stable(prog_cmd_data_out) && $stable(prog_cmd_op_out))
        else $error("command word changed without strobe");
    a_prog_pads: assert property (s_prog ##1 s_prog |-> pad_oe_out == '0 && pad_out == '0)
        else $error("pins driven in programming mode");
    a_core_follow: assert property (s_normal ##1 s_normal |->
        pad_out == $past(core_out_in) && pad_oe_out == $past(core_oe_in))
        else $error("pins do not follow core logic");
endmodule
bind jbs_tap_top jbs_tap_checker #(.BSR_LEN(BSR_LEN), .PROG_DR_LEN(PROG_DR_LEN)) u_chk (
    .clock_in, .srst_in, .jtag_en_in, .tdo_oe_out, .jtag_released_out, .core_out_in,
    .core_oe_in, .pad_out, .pad_oe_out, .extest_active_out, .prog_mode_out,
    .prog_cmd_valid_out, .prog_cmd_op_out, .prog_cmd_data_out
);

/* sim/jbs_tap_ctrl.sv */
`timescale 1ns/1ps
module jbs_tap_ctrl (
    output logic tck_out,
    output logic tms_out,
    output logic tdi_out,
    input wire logic tdo_in
);
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b0;
    end
    // One 160 ns test clock; clock stands still between calls
    task automatic step(input logic tms_v, input logic tdi_v, output logic tdo_v);
        tms_out = tms_v;
        tdi_out = tdi_v;
        #80;
        tdo_v = tdo_in;
        tck_out = 1'b1;
        #80;
        tck_out = 1'b0;
    endtask
    // Data line not in use toggles
    task automatic idle(input logic tms_v);
        logic b;
        step(tms_v, ~tdi_out, b);
    endtask
    task automatic tap_reset;
        repeat (5) idle(1'b1);
        idle(1'b0);
    endtask
    // Idle to idle, LSB first
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
        output logic [31:0] dout);
        logic b;
        dout = '0;
        idle(1'b1);
        if (ir) begin
            idle(1'b1);
        end
        idle(1'b0);
        idle(1'b0);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], b);
            dout[i] = b;
        end
        idle(1'b1);
        idle(1'b0);
    endtask
endmodule

/* sim/jbs_tap_top_bench.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, (a), (b)); end end
module jbs_tap_top_bench
    import jbs_pkg::*;
;
    // Arbitrary identification fields
    localparam logic [3:0] VER = 4'h3;
    localparam logic [15:0] PART = 16'h1E2D;
    localparam logic [10:0] MFR = 11'h0F1;
    logic clock_in = 1'b0;
    logic srst_in = 1'b1;
    logic jtag_en = 1'b1;
    logic tck, tms, tdi, tdo, tdo_oe, released, tdo_line, extest, prog_mode, cmd_valid;
    logic [1:0] pad_in = '0, core_out = '0, core_oe = '0, pad_out, pad_oe;
    logic [15:0] rd_data = '0, cmd_data;
    jbs_prog_op_t cmd_op;
    int failures = 0, compares = 0, cycles = 0, pulses = 0;
    always #50 clock_in = ~clock_in;
    assign tdo_line = (tdo_oe === 1'b1) ? tdo : cycles[0];
    jbs_tap_top #(.BSR_LEN(6), .PROG_DR_LEN(16), .ID_VERSION(VER),
        .ID_PART(PART), .ID_MFR(MFR)) dut (
        .clock_in(clock_in), .srst_in(srst_in), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
        .jtag_en_in(jtag_en), .tdo_out(tdo), .tdo_oe_out(tdo_oe),
        .jtag_released_out(released), .pad_in(pad_in), .core_out_in(core_out),
        .core_oe_in(core_oe), .pad_out(pad_out), .pad_oe_out(pad_oe),
        .extest_active_out(extest), .prog_mode_out(prog_mode), .prog_rd_data_in(rd_data),
        .prog_cmd_valid_out(cmd_valid), .prog_cmd_op_out(cmd_op),
        .prog_cmd_data_out(cmd_data)
    );
    jbs_tap_ctrl ctrl (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo_line));
    task automatic end_of_test;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge clock_in) begin
        cycles++;
        if (cmd_valid === 1'b1) begin
            pulses++;
        end
        if (cycles == 20000) begin
            failures++;
            end_of_test();
        end
    end
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clock_in);
    endtask
    task automatic ir(input logic [9:0] c, output logic [9:0] cap);
        logic [31:0] d;
        ctrl.scan(1'b1, IR_LEN, {22'h0, c}, d);
        cap = d[9:0];
    endtask
    task automatic t_idcode;
        logic [31:0] d;
        logic [9:0] cap;
        ctrl.scan(1'b0, ID_LEN, 32'h0, d);
        `CHK(d, {VER, PART, MFR, 1'b1})
        `CHK(d[ID_ONE_BIT], ID_ONE_VAL)
        ir(IR_IDCODE, cap);
        ctrl.scan(1'b0, ID_LEN, 32'h0, d);
        `CHK(d, {VER, PART, MFR, 1'b1})
    endtask
    task automatic t_bypass;
        logic [31:0] d;
        logic [9:0] cap;
        logic [9:0] codes [3];
        codes = '{IR_BYPASS, 10'h123, 10'h3FE};
        foreach (codes[i]) begin
            ir(codes[i], cap);
            `CHK(cap, IR_CAPTURE_VAL)
            ctrl.scan(1'b0, 8, 32'hA5, d);
            `CHK(d[7:0], 8'h4A)
            `CHK(tdo_oe, 1'b0)
        end
    endtask
    task automatic t_scan;
        logic [31:0] d;
        logic [9:0] cap;
        wait_clk(1);
        pad_in = 2'b10;
        core_out = 2'b01;
        core_oe = 2'b10;
        wait_clk(2);
        `CHK({pad_oe, pad_out}, {core_oe, core_out})
        ir(IR_SAMPLE, cap);
        ctrl.scan(1'b0, 6, 32'h26, d);
        `CHK({d[3], d[0]}, pad_in)
        wait_clk(8);
        `CHK({extest, pad_out}, {1'b0, core_out})
        ir(IR_EXTEST, cap);
        wait_clk(8);
        `CHK({extest, pad_oe, pad_out}, 5'h1D)
        pad_in = 2'b01;
        ctrl.scan(1'b0, 6, 32'h0, d);
        `CHK({d[3], d[0]}, 2'b01)
        wait_clk(8);
        `CHK({pad_oe, pad_out}, 4'h0)
        ir(IR_BYPASS, cap);
    endtask
    task automatic t_prog;
        logic [31:0] d;
        logic [9:0] cap;
        logic [9:0] codes [3];
        jbs_prog_op_t ops [3];
        logic [15:0] words [3];
        codes = '{IR_PROG_ADDR, IR_PROG_WRITE, IR_PROG_VERIFY};
        ops = '{OP_ADDR, OP_WRITE, OP_VERIFY};
        words = '{16'h0123, 16'hBEEF, 16'h7E81};
        wait_clk(1);
        rd_data = 16'h5AA5;
        ir(IR_PROG_WRITE, cap);
        ctrl.scan(1'b0, 16, 32'hBEEF, d);
        wait_clk(8);
        `CHK(pulses, 0)
        ir(IR_PROG_ENTER, cap);
        wait_clk(8);
        `CHK({prog_mode, pad_oe, pad_out}, 5'h10)
        foreach (codes[i]) begin
            ir(codes[i], cap);
            ctrl.scan(1'b0, 16, {16'h0, words[i]}, d);
            wait_clk(8);
            `CHK(pulses, i + 1)
            `CHK({cmd_op, cmd_data}, {ops[i], words[i]})
        end
        `CHK(d[15:0], 16'h5AA5)
        ir(IR_PROG_ERASE, cap);
        wait_clk(8);
        `CHK(cmd_op, OP_ERASE)
        `CHK(pulses, 4)
        ir(IR_PROG_EXIT, cap);
        wait_clk(8);
        `CHK(prog_mode, 1'b0)
    endtask
    task automatic t_release;
        logic [31:0] d;
        logic [9:0] cap;
        ir(IR_BYPASS, cap);
        wait_clk(1);
        jtag_en = 1'b0;
        repeat (4) ctrl.idle(1'b0);
        `CHK({released, tdo_oe}, 2'b10)
        wait_clk(1);
        jtag_en = 1'b1;
        repeat (4) ctrl.idle(1'b0);
        `CHK(released, 1'b0)
        ctrl.scan(1'b0, ID_LEN, 32'h0, d);
        `CHK(d, {VER, PART, MFR, 1'b1})
    endtask
    initial begin
        wait_clk(1);
        repeat (5) ctrl.idle(1'b1);
        wait_clk(1);
        srst_in = 1'b0;
        ctrl.tap_reset();
        t_idcode();
        t_bypass();
        t_scan();
        t_prog();
        t_release();
        end_of_test();
    end
endmodule
